/* File: logic/thermal_event_defs.vh */
// constants shared by the thermal overload event recorder
`ifndef THERMAL_EVENT_DEFS_VH
`define THERMAL_EVENT_DEFS_VH

// data widths
`define CAP_W 16
`define TS_W 48
`define CNT_W 32
`define DLY_W 22
`define TIME_W 32
`define SG_W 3
`define EV_W 4

// operation record store
`define REC_DEPTH 12
`define REC_IDX_W 4
`define REC_W 205

// event codes: even is ON, odd is OFF; status bit k gives 2k / 2k+1
`define EV_ALARM1_ON 4'h0
`define EV_ALARM1_OFF 4'h1
`define EV_ALARM2_ON 4'h2
`define EV_ALARM2_OFF 4'h3
`define EV_INHIBIT_ON 4'h4
`define EV_INHIBIT_OFF 4'h5
`define EV_TRIP_ON 4'h6
`define EV_TRIP_OFF 4'h7
`define EV_BLOCK_ON 4'h8
`define EV_BLOCK_OFF 4'h9
`define EV_COUNT 10
`define ST_COUNT 5

// event polarity select bits
`define EVSEL_ON_BIT 0
`define EVSEL_OFF_BIT 1
`define EVSEL_RESET 2'h3

// timing: one millisecond tick from the system clock
`define CLK_PERIOD_PS 4000
`define MS_PS 1000000000
`define MS_CYCLES (`MS_PS / `CLK_PERIOD_PS)

`endif

/* File: logic/sat_counter.v */
// saturating event counter with synchronous clear
`timescale 1ns/100ps
`include "thermal_event_defs.vh"

module sat_counter #(
	parameter WIDTH = `CNT_W
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_reset,
	// control
	input wire i_inc,
	input wire i_clear,
	// value
	output reg [WIDTH-1:0] o_count
);

	// all ones means the count is pinned
	wire full = &o_count;

	// clear wins over increment: a clear command empties the count
	always @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_count <= {WIDTH{1'b0}};
		end else if (i_clear) begin
			o_count <= {WIDTH{1'b0}};
		end else if (i_inc && !full) begin
			// stops at the top rather than wrapping back to zero
			o_count <= o_count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

endmodule

/* File: logic/thermal_overload_event_recorder.v */
// thermal overload stage outputs, counters, events and fault records
//
// Operation
// - count first alarm activations
// - count second alarm activations
// - count restart inhibit activations
// - count stage trips
// - count trips prevented by blocking
// - counters saturate, cleared by command or reset
// - ON/OFF event per status edge, ten codes
// - event polarity filter: ON, OFF, both
// - time stamp taken at the transition
// - keep last twelve stamped operation records
// - record only on trip or block ON
// - record holds stamp, event and process data
// - release times per limit while cooling
// - two-state trip expectation flag
// - enabled alarm and inhibit outputs assert at capacity threshold, trip after its delay
// - block at pick-up gives blocked, not trip
`timescale 1ns/100ps
`include "thermal_event_defs.vh"

module thermal_overload_event_recorder #(
	parameter MS_CYCLES = `MS_CYCLES
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_reset,
	// thermal image values
	input wire [`CAP_W-1:0] i_capacity,
	input wire [`CAP_W-1:0] i_capacity_est,
	input wire i_cooling,
	input wire [`TIME_W-1:0] i_trip_rel_time,
	input wire [`TIME_W-1:0] i_alarm1_rel_time,
	input wire [`TIME_W-1:0] i_alarm2_rel_time,
	input wire [`TIME_W-1:0] i_inhibit_rel_time,
	input wire [`CAP_W-1:0] i_time_to_full,
	input wire [`CAP_W-1:0] i_ref_current,
	input wire [`CAP_W-1:0] i_meas_current,
	input wire [`CAP_W-1:0] i_max_temp_rise,
	input wire [`CAP_W-1:0] i_temp_rise,
	input wire [`CAP_W-1:0] i_hot_spot,
	input wire [`CAP_W-1:0] i_hot_spot_max,
	input wire [`SG_W-1:0] i_setting_group,
	// settings
	input wire i_alarm1_en,
	input wire i_alarm2_en,
	input wire i_inhibit_en,
	input wire i_trip_en,
	input wire [`CAP_W-1:0] i_alarm1_level,
	input wire [`CAP_W-1:0] i_alarm2_level,
	input wire [`CAP_W-1:0] i_inhibit_level,
	input wire [`CAP_W-1:0] i_trip_level,
	input wire [`DLY_W-1:0] i_trip_delay_ms,
	input wire [1:0] i_event_select,
	input wire i_count_clear,
	// blocking input and real-time stamp
	input wire i_block,
	input wire [`TS_W-1:0] i_timestamp,
	// stage outputs
	output reg o_alarm1,
	output reg o_alarm2,
	output reg o_inhibit,
	output reg o_trip,
	output reg o_blocked,
	output reg o_trip_expected,
	output reg [`DLY_W-1:0] o_trip_delay_rem,
	// release times during cooling
	output reg [`TIME_W-1:0] o_trip_rel_time,
	output reg [`TIME_W-1:0] o_alarm1_rel_time,
	output reg [`TIME_W-1:0] o_alarm2_rel_time,
	output reg [`TIME_W-1:0] o_inhibit_rel_time,
	// counters
	output wire [`CNT_W-1:0] o_first_alarm_count,
	output wire [`CNT_W-1:0] o_second_alarm_count,
	output wire [`CNT_W-1:0] o_inhibit_count,
	output wire [`CNT_W-1:0] o_trip_count,
	output wire [`CNT_W-1:0] o_blocked_count,
	// event stream to the shared event buffer
	output wire o_event_valid,
	input wire i_event_ready,
	output reg [`EV_W-1:0] o_event_code,
	output reg [`TS_W-1:0] o_event_time,
	// record read port
	input wire [`REC_IDX_W-1:0] i_rec_index,
	output reg [`REC_W-1:0] o_rec_data,
	output reg [`REC_IDX_W-1:0] o_rec_count
);

	// threshold compare per output (levels in the capacity's units)
	wire pick_a1 = i_alarm1_en && (i_capacity >= i_alarm1_level);
	wire pick_a2 = i_alarm2_en && (i_capacity >= i_alarm2_level);
	wire pick_inh = i_inhibit_en && (i_capacity >= i_inhibit_level);
	wire pick_trip = i_trip_en && (i_capacity >= i_trip_level);

	// millisecond tick divider
	reg [31:0] ms_div;
	wire ms_tick = (ms_div == MS_CYCLES - 1);

	always @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			ms_div <= 32'h0;
		end else if (ms_tick) begin
			ms_div <= 32'h0;
		end else begin
			ms_div <= ms_div + 32'h1;
		end
	end

	// next state of the stage outputs
	reg next_trip;
	reg next_blocked;
	reg [`DLY_W-1:0] next_dly;

	always @* begin
		next_trip = 1'b0;
		next_blocked = 1'b0;
		next_dly = o_trip_delay_rem;
		if (!pick_trip) begin
			// pick-up gone: reload the delay for the next overload
			next_dly = i_trip_delay_ms;
		end else if (i_block) begin
			// blocked: no start, delay restarts once block lifts
			next_blocked = 1'b1;
			next_dly = i_trip_delay_ms;
		end else if (o_trip_delay_rem == {`DLY_W{1'b0}}) begin
			next_trip = 1'b1;
		end else if (ms_tick) begin
			next_dly = o_trip_delay_rem - {{(`DLY_W-1){1'b0}}, 1'b1};
		end
	end

	// status vector: bit order matches event code pairs
	wire [`ST_COUNT-1:0] cur_st = {o_blocked, o_trip, o_inhibit,
		o_alarm2, o_alarm1};
	wire [`ST_COUNT-1:0] next_st = {next_blocked, next_trip, pick_inh,
		pick_a2, pick_a1};
	wire [`ST_COUNT-1:0] st_rise = next_st & ~cur_st;
	wire [`ST_COUNT-1:0] st_fall = ~next_st & cur_st;

	// stage outputs and timing status registers
	always @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_alarm1 <= 1'b0;
			o_alarm2 <= 1'b0;
			o_inhibit <= 1'b0;
			o_trip <= 1'b0;
			o_blocked <= 1'b0;
			o_trip_expected <= 1'b0;
			o_trip_delay_rem <= {`DLY_W{1'b0}};
			o_trip_rel_time <= {`TIME_W{1'b0}};
			o_alarm1_rel_time <= {`TIME_W{1'b0}};
			o_alarm2_rel_time <= {`TIME_W{1'b0}};
			o_inhibit_rel_time <= {`TIME_W{1'b0}};
		end else begin
			o_alarm1 <= pick_a1;
			o_alarm2 <= pick_a2;
			o_inhibit <= pick_inh;
			o_trip <= next_trip;
			o_blocked <= next_blocked;
			o_trip_delay_rem <= next_dly;
			// expectation uses the estimate with the present current
			o_trip_expected <= (i_capacity_est >= i_trip_level);
			// a time only means something while above its limit
			o_trip_rel_time <= (i_cooling &&
				i_capacity >= i_trip_level) ? i_trip_rel_time :
				{`TIME_W{1'b0}};
			o_alarm1_rel_time <= (i_cooling &&
				i_capacity >= i_alarm1_level) ? i_alarm1_rel_time :
				{`TIME_W{1'b0}};
			o_alarm2_rel_time <= (i_cooling &&
				i_capacity >= i_alarm2_level) ? i_alarm2_rel_time :
				{`TIME_W{1'b0}};
			o_inhibit_rel_time <= (i_cooling &&
				i_capacity >= i_inhibit_level) ? i_inhibit_rel_time :
				{`TIME_W{1'b0}};
		end
	end

	// activation counters, one per status bit
	wire [`ST_COUNT*`CNT_W-1:0] counts;
	genvar g;
	generate
		for (g = 0; g < `ST_COUNT; g = g + 1) begin : cnt
			sat_counter #(.WIDTH(`CNT_W)) u_cnt (
				.i_clk_sys(i_clk_sys),
				.i_reset(i_reset),
				.i_inc(st_rise[g]),
				.i_clear(i_count_clear),
				.o_count(counts[g*`CNT_W +: `CNT_W])
			);
		end
	endgenerate

	assign o_first_alarm_count = counts[0*`CNT_W +: `CNT_W];
	assign o_second_alarm_count = counts[1*`CNT_W +: `CNT_W];
	assign o_inhibit_count = counts[2*`CNT_W +: `CNT_W];
	assign o_trip_count = counts[3*`CNT_W +: `CNT_W];
	assign o_blocked_count = counts[4*`CNT_W +: `CNT_W];

	// raw event requests after the polarity filter
	reg [`EV_COUNT-1:0] ev_set;
	integer k_sel, k_pick, k_pend, k_ts;

	always @* begin
		ev_set = {`EV_COUNT{1'b0}};
		for (k_sel = 0; k_sel < `ST_COUNT; k_sel = k_sel + 1) begin
			ev_set[2*k_sel] = st_rise[k_sel] &&
				i_event_select[`EVSEL_ON_BIT];
			ev_set[2*k_sel+1] = st_fall[k_sel] &&
				i_event_select[`EVSEL_OFF_BIT];
		end
	end

	// one pending flag and stamp per code; bursts drain one per cycle
	reg [`EV_COUNT-1:0] ev_pend;
	reg [`TS_W-1:0] ev_ts [0:`EV_COUNT-1];
	reg out_valid;
	reg [`EV_W-1:0] pick_code;
	reg pick_any;

	// lowest pending code goes first
	always @* begin
		pick_code = {`EV_W{1'b0}};
		pick_any = 1'b0;
		for (k_pick = `EV_COUNT - 1; k_pick >= 0; k_pick = k_pick - 1) begin
			if (ev_pend[k_pick]) begin
				pick_code = k_pick[`EV_W-1:0];
				pick_any = 1'b1;
			end
		end
	end

	wire out_load = pick_any && (!out_valid || i_event_ready);
	assign o_event_valid = out_valid;

	// pending flags: a new edge in the cycle of the take wins
	always @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			ev_pend <= {`EV_COUNT{1'b0}};
		end else begin
			for (k_pend = 0; k_pend < `EV_COUNT; k_pend = k_pend + 1) begin
				if (ev_set[k_pend]) begin
					ev_pend[k_pend] <= 1'b1;
				end else if (out_load && pick_code == k_pend) begin
					ev_pend[k_pend] <= 1'b0;
				end
			end
		end
	end

	// stamp taken on the edge that registers the new status
	always @(posedge i_clk_sys) begin
		for (k_ts = 0; k_ts < `EV_COUNT; k_ts = k_ts + 1) begin
			if (ev_set[k_ts]) begin
				ev_ts[k_ts] <= i_timestamp;
			end
		end
	end

	// event output holding register
	always @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			out_valid <= 1'b0;
			o_event_code <= {`EV_W{1'b0}};
			o_event_time <= {`TS_W{1'b0}};
		end else if (out_load) begin
			out_valid <= 1'b1;
			o_event_code <= pick_code;
			o_event_time <= ev_ts[pick_code];
		end else if (i_event_ready) begin
			out_valid <= 1'b0;
		end
	end

	// operation record ring, written only on trip ON or block ON
	reg [`REC_W-1:0] rec_mem [0:`REC_DEPTH-1];
	reg [`REC_IDX_W-1:0] rec_wp;
	wire rec_take = st_rise[3] || st_rise[4];
	wire [`EV_W-1:0] rec_code = st_rise[4] ? `EV_BLOCK_ON : `EV_TRIP_ON;
	wire [`REC_W-1:0] rec_word = {i_timestamp, rec_code, i_time_to_full,
		i_ref_current, i_meas_current, i_capacity, i_max_temp_rise,
		i_temp_rise, i_hot_spot, i_hot_spot_max, next_dly,
		i_setting_group};

	// write pointer wraps, so the oldest slot is reused when full
	always @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			rec_wp <= {`REC_IDX_W{1'b0}};
			o_rec_count <= {`REC_IDX_W{1'b0}};
		end else if (rec_take) begin
			if (rec_wp == `REC_DEPTH - 1) begin
				rec_wp <= {`REC_IDX_W{1'b0}};
			end else begin
				rec_wp <= rec_wp + 4'h1;
			end
			if (o_rec_count != `REC_DEPTH) begin
				o_rec_count <= o_rec_count + 4'h1;
			end
		end
	end

	// storage has no reset: slots past the count are never shown
	always @(posedge i_clk_sys) begin
		if (rec_take) begin
			rec_mem[rec_wp] <= rec_word;
		end
	end

	// index 0 is the newest record, counting back in time
	reg [`REC_IDX_W-1:0] rd_addr;

	always @* begin
		if (rec_wp > i_rec_index) begin
			rd_addr = rec_wp - i_rec_index - 4'h1;
		end else begin
			rd_addr = rec_wp + 4'hb - i_rec_index;
		end
	end

	// registered read, zero for an index with no record behind it
	always @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_rec_data <= {`REC_W{1'b0}};
		end else if (i_rec_index < o_rec_count) begin
			o_rec_data <= rec_mem[rd_addr];
		end else begin
			o_rec_data <= {`REC_W{1'b0}};
		end
	end

endmodule

/* File: tb/event_buffer_model.sv */
// event buffer model: takes events, stalling at random
`timescale 1ns/100ps

module event_buffer_model (
	// clock and reset
	input wire i_clk_sys,
	input wire i_reset,
	// event port
	input wire i_event_valid,
	input wire i_stall_en,
	output reg o_event_ready
);
	integer seed = 32'h08d8;
	// stalls make events wait and pile up inside the recorder
	always @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset)
			o_event_ready <= 1'b0;
		else
			o_event_ready <= !i_stall_en || ($random(seed) & 1);
	end
endmodule

/* File: tb/thermal_overload_event_recorder_sva.sv */
// assertions on the recorder ports
`timescale 1ns/100ps
`include "thermal_event_defs.vh"

module thermal_recorder_checker (
	// clock and reset
	input wire i_clk_sys,
	input wire i_reset,
	// watched inputs
	input wire [`CAP_W-1:0] i_capacity,
	input wire i_alarm1_en,
	input wire [`CAP_W-1:0] i_alarm1_level,
	input wire i_trip_en,
	input wire [`CAP_W-1:0] i_trip_level,
	input wire i_block,
	input wire i_cooling,
	input wire i_count_clear,
	input wire i_event_ready,
	// watched outputs
	input wire o_alarm1,
	input wire o_trip,
	input wire o_blocked,
	input wire [`CNT_W-1:0] o_first_alarm_count,
	input wire [`CNT_W-1:0] o_trip_count,
	input wire [`CNT_W-1:0] o_blocked_count,
	input wire o_event_valid,
	input wire [`EV_W-1:0] o_event_code,
	input wire [`REC_IDX_W-1:0] o_rec_count,
	input wire [`TIME_W-1:0] o_trip_rel_time
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_reset);
	// outputs are registered: compare with inputs one edge back
	property p_a1;
		!$past(i_reset) |-> o_alarm1 ==
			$past(i_alarm1_en && i_capacity >= i_alarm1_level);
	endproperty
	a_a1: assert property (p_a1) else $error("alarm1 level");
	property p_a1_cnt;
		$rose(o_alarm1) && !$past(i_count_clear) |->
			o_first_alarm_count == $past(o_first_alarm_count) + 32'h1;
	endproperty
	a_a1_cnt: assert property (p_a1_cnt) else $error("alarm1 count");
	property p_trip_cnt;
		$rose(o_trip) && !$past(i_count_clear) |->
			o_trip_count == $past(o_trip_count) + 32'h1;
	endproperty
	a_trip_cnt: assert property (p_trip_cnt) else $error("trip count");
	// the blocked count never moves on its own
	property p_blk_hold;
		!$rose(o_blocked) && !$past(i_count_clear) |->
			$stable(o_blocked_count);
	endproperty
	a_blk_hold: assert property (p_blk_hold) else $error("blk count");
	property p_blk;
		!$past(i_reset) && $past(i_trip_en && i_block &&
			i_capacity >= i_trip_level) |-> o_blocked && !o_trip;
	endproperty
	a_blk: assert property (p_blk) else $error("blocked trip");
	property p_ev_hold;
		o_event_valid && !i_event_ready |=>
			o_event_valid && $stable(o_event_code);
	endproperty
	a_ev_hold: assert property (p_ev_hold) else $error("event lost");
	// the store saturates at twelve, the oldest is then replaced
	property p_rec;
		$rose(o_trip) || $rose(o_blocked) |-> o_rec_count ==
			($past(o_rec_count) < 12 ? $past(o_rec_count) + 1 : 12);
	endproperty
	a_rec: assert property (p_rec) else $error("record count");
	property p_rel; !$past(i_cooling) |-> o_trip_rel_time == 0; endproperty
	a_rel: assert property (p_rel) else $error("release time");
	c_trip: cover property ($rose(o_trip));
	c_blk: cover property ($rose(o_blocked));
	c_stall: cover property (o_event_valid && !i_event_ready);
endmodule

bind thermal_overload_event_recorder thermal_recorder_checker chk (.*);

/* File: tb/testbench.sv */
// self-checking bench for the thermal overload event recorder
`timescale 1ns/100ps

module testbench;
	logic i_clk_sys = 0;
	logic i_reset = 1;
	logic [15:0] i_capacity, i_capacity_est, i_time_to_full, i_ref_current;
	logic [15:0] i_meas_current, i_max_temp_rise, i_temp_rise, i_hot_spot;
	logic [15:0] i_hot_spot_max, i_alarm1_level, i_alarm2_level;
	logic [15:0] i_inhibit_level, i_trip_level;
	logic [31:0] i_trip_rel_time, i_alarm1_rel_time, i_alarm2_rel_time;
	logic [31:0] i_inhibit_rel_time;
	logic [21:0] i_trip_delay_ms;
	logic [47:0] i_timestamp, ts;
	logic [3:0] i_rec_index;
	logic [2:0] i_setting_group;
	logic [1:0] i_event_select;
	logic i_cooling, i_alarm1_en, i_alarm2_en, i_inhibit_en, i_trip_en;
	logic i_count_clear, i_block, stall;
	wire i_event_ready, o_alarm1, o_alarm2, o_inhibit, o_trip, o_blocked;
	wire o_trip_expected, o_event_valid;
	wire [21:0] o_trip_delay_rem;
	wire [31:0] o_trip_rel_time, o_alarm1_rel_time, o_alarm2_rel_time;
	wire [31:0] o_inhibit_rel_time, o_first_alarm_count, o_second_alarm_count;
	wire [31:0] o_inhibit_count, o_trip_count, o_blocked_count;
	wire [3:0] o_event_code, o_rec_count;
	wire [47:0] o_event_time;
	wire [204:0] o_rec_data;
	logic [51:0] q[$], note;
	logic [204:0] recs[12];
	integer seed = 32'h08d8;
	integer fails = 0;
	integer n_compared = 0;
	integer n;

	thermal_overload_event_recorder #(.MS_CYCLES(4)) dut (.*);
	event_buffer_model buffer (.i_clk_sys, .i_reset,
		.i_event_valid(o_event_valid), .i_stall_en(stall),
		.o_event_ready(i_event_ready));

	always #2 i_clk_sys = ~i_clk_sys;

	task chk(input string s, input [204:0] e, input [204:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask
	task finish_test;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task cyc(input int k);
		repeat (k) @(posedge i_clk_sys);
	endtask
	// new level with fresh data and stamp, held until the next step
	task step(input [15:0] cap, input blk);
		@(posedge i_clk_sys);
		ts = {$random(seed), 16'h0};
		i_timestamp <= ts;
		i_capacity <= cap;
		i_block <= blk;
		{i_time_to_full, i_ref_current, i_meas_current, i_max_temp_rise} <=
			{$random(seed), $random(seed)};
		{i_temp_rise, i_hot_spot} <= $random(seed);
		i_hot_spot_max <= 16'($random(seed));
		// estimate spread around the trip level so both flag states occur
		i_capacity_est <= 16'($random(seed)) & 16'h07ff;
		{i_trip_rel_time, i_alarm1_rel_time} <= {$random(seed), $random(seed)};
		{i_alarm2_rel_time, i_inhibit_rel_time} <= {$random(seed), $random(seed)};
		i_setting_group <= 3'($random(seed));
	endtask
	// note events of codes c, c+2, ...; unselected polarity is dropped
	task evs(input [3:0] c, input int k);
		for (int j = 0; j < k; j++)
			if (i_event_select[c[0]])
				q.push_back({c + 4'(2 * j), ts});
	endtask
	function [204:0] rec(input [3:0] c);
		rec = {i_timestamp, c, i_time_to_full, i_ref_current, i_meas_current,
			i_capacity, i_max_temp_rise, i_temp_rise, i_hot_spot,
			i_hot_spot_max, 22'h0, i_setting_group};
	endfunction
	task rec_chk(input [3:0] i, input [204:0] e);
		i_rec_index <= i;
		cyc(2);
		chk("record", e, o_rec_data);
	endtask

	// the oldest note is compared whenever the buffer takes an event
	always @(posedge i_clk_sys) begin
		if (!i_reset && o_event_valid && i_event_ready) begin
			note = q.size() ? q.pop_front() : 'x;
			chk("event", note, {o_event_code, o_event_time});
		end
	end

	initial begin
		{i_capacity, i_block, i_cooling, i_count_clear, i_rec_index} = '0;
		{i_alarm1_en, i_alarm2_en, i_inhibit_en, i_trip_en, stall} = 5'h1f;
		{i_alarm1_level, i_alarm2_level} = {16'h0190, 16'h0258};
		{i_inhibit_level, i_trip_level} = {16'h0320, 16'h03e8};
		{i_trip_delay_ms, i_event_select, ts, i_timestamp} = {22'h0, 2'h3, 96'h0};
		{i_time_to_full, i_ref_current, i_meas_current, i_hot_spot} = '0;
		{i_max_temp_rise, i_temp_rise, i_hot_spot_max, i_capacity_est} = '0;
		{i_setting_group, i_trip_rel_time, i_alarm1_rel_time} = '0;
		{i_alarm2_rel_time, i_inhibit_rel_time} = '0;
		cyc(20);
		i_reset <= 0;
		// alarm levels, counts, release times while cooling
		step(16'h02bc, 0);
		evs(0, 2);
		cyc(16);
		chk("a1 count", 1, o_first_alarm_count);
		chk("a2 count", 1, o_second_alarm_count);
		i_cooling <= 1;
		step(16'h0384, 0);
		evs(4, 1);
		cyc(16);
		chk("inh count", 1, o_inhibit_count);
		chk("a1 rel", i_alarm1_rel_time, o_alarm1_rel_time);
		chk("trip rel", 0, o_trip_rel_time);
		chk("a2 rel", i_alarm2_rel_time, o_alarm2_rel_time);
		chk("inh rel", i_inhibit_rel_time, o_inhibit_rel_time);
		chk("inh out", 1, o_inhibit);
		i_cooling <= 0;
		step(16'h0064, 0);
		evs(1, 3);
		cyc(16);
		i_alarm2_en <= 0;
		step(16'h02bc, 0);
		evs(0, 1);
		cyc(16);
		chk("a2 count", 1, o_second_alarm_count);
		step(16'h0064, 0);
		evs(1, 1);
		cyc(16);
		i_alarm2_en <= 1;
		$display("test alarms done");
		// trip after 2 ms of 4 cycles each
		i_trip_delay_ms <= 22'h2;
		step(16'h03e8, 0);
		evs(0, 4);
		cyc(1);
		chk("delay rem", 2, o_trip_delay_rem);
		cyc(5);
		chk("trip early", 0, o_trip);
		// two ticks of four cycles plus one edge, whatever the tick phase
		for (n = 0; n < 4 && o_trip !== 1'b1; n++)
			cyc(1);
		chk("trip late", 1, o_trip);
		if (o_trip !== 1'b1)
			finish_test;
		cyc(16);
		chk("trip count", 1, o_trip_count);
		chk("rec count", 1, o_rec_count);
		step(16'h0064, 0);
		evs(1, 4);
		cyc(16);
		$display("test trip delay done");
		// blocking at pick-up: blocked instead of a trip
		i_trip_delay_ms <= 22'h0;
		step(16'h03e8, 1);
		evs(0, 3);
		evs(8, 1);
		cyc(16);
		chk("blk count", 1, o_blocked_count);
		chk("trip count", 1, o_trip_count);
		rec_chk(0, rec(8));
		step(16'h0064, 0);
		evs(1, 3);
		evs(9, 1);
		cyc(16);
		$display("test blocking done");
		for (int s = 1; s < 3; s++) begin
			i_event_select <= 2'(s);
			step(16'h02bc, 0);
			evs(0, 2);
			cyc(16);
			step(16'h0064, 0);
			evs(1, 2);
			cyc(16);
		end
		i_event_select <= 2'h3;
		$display("test polarity done");
		// fourteen captures: the two oldest are overwritten
		stall <= 0;
		for (int k = 0; k < 12; k++) begin
			step(16'h03e8, 0);
			evs(0, 4);
			cyc(16);
			recs[k] = rec(6);
			chk("stage on", 4'hf,
				{o_trip, o_inhibit, o_alarm2, o_alarm1});
			chk("trip expect", i_capacity_est >= i_trip_level,
				o_trip_expected);
			step(16'h0064, 0);
			evs(1, 4);
			cyc(16);
			chk("stage off", 4'h0,
				{o_trip, o_inhibit, o_alarm2, o_alarm1});
		end
		chk("rec count", 12, o_rec_count);
		rec_chk(0, recs[11]);
		rec_chk(11, recs[0]);
		rec_chk(12, 0);
		$display("test records done");
		chk("a1 count", 18, o_first_alarm_count);
		chk("trip count", 13, o_trip_count);
		i_count_clear <= 1;
		cyc(1);
		i_count_clear <= 0;
		cyc(2);
		chk("cleared", 0, o_trip_count);
		cyc(40);
		chk("events left", 0, q.size());
		$display("test clear done");
		finish_test;
	end
endmodule
